//--- inc/rapd_map.svh
// Register offsets, field positions, reset values and arithmetic constants
`ifndef RAPD_MAP_SVH
`define RAPD_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RAPD_OFS_CONFIG 8'h00
`define RAPD_OFS_STATUS 8'h04
`define RAPD_OFS_MASK 8'h08
`define RAPD_OFS_THRESH 8'h0c
`define RAPD_OFS_RMS_OFFSET 8'h10
`define RAPD_OFS_PWR_GAIN 8'h30
`define RAPD_OFS_PWR_OFFSET 8'h3c
`define RAPD_OFS_RMS_RESULT 8'h48
`define RAPD_OFS_PWR_RESULT 8'h68

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RAPD_CFG_ISUM_SEL_LSB 0
`define RAPD_CFG_BYPASS_BIT 2
`define RAPD_ST_MISMATCH_BIT 0
`define RAPD_ST_UPDATE_BIT 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RAPD_RST_WORD 32'h0000_0000
`define RAPD_RST_STATUS 2'h0
`define RAPD_RST_SQRT_BIT 64'h4000_0000_0000_0000

// ----------------------------------------
// Arithmetic scaling
// ----------------------------------------
`define RAPD_LPF_SHIFT 10
`define RAPD_RMS_OFS_SHIFT 15
`define RAPD_GAIN_SHIFT 27
`define RAPD_PWR_SHIFT 27

`endif

//--- inc/rapd_pkg.sv
// Types shared by the rms and active power datapath
package rapd_pkg;

	typedef logic signed [31:0] rapd_sample_t;

	// Compensated waveforms of one processing sample
	typedef struct packed {
		rapd_sample_t ia;
		rapd_sample_t ib;
		rapd_sample_t ic;
		rapd_sample_t ni;
		rapd_sample_t va;
		rapd_sample_t vb;
		rapd_sample_t vc;
	} rapd_wave_s;

	typedef struct packed {
		logic bypass;
		logic [1:0] isum_sel;
	} rapd_cfg_s;

	typedef enum logic [4:0] {
		RAPD_IDLE = 5'b00001,
		RAPD_FILT = 5'b00010,
		RAPD_ROOT = 5'b00100,
		RAPD_PWR = 5'b01000,
		RAPD_COMMIT = 5'b10000
	} rapd_state_e;

endpackage : rapd_pkg

//--- rtl/rapd_datapath.sv
// Rms, current-sum rms, mismatch flag and active power datapath with Avalon-MM registers
// What this block does
// RULE1 - Each channel rms is square, low-pass filter, then square root.
// RULE2 - All seven channel rms results refresh once per sample strobe.
// RULE3 - Full-scale sine gives rms code 52,866,837.
// RULE4 - Rms offset times 2^15 is added to squared rms before root.
// RULE5 - Neutral rms uses its own offset and the same arithmetic.
// RULE6 - Current-sum rms uses the same method, rate, scaling, own offset.
// RULE7 - Select 00 or 11 sums only the three phase currents.
// RULE8 - Select 01 adds neutral, 10 subtracts neutral.
// RULE9 - A change of sum rms versus threshold sets mismatch flag and interrupt.
// RULE10 - Power is current times voltage, filtered unless bypassed, gained, offset.
// RULE11 - Each phase power result refreshes once per sample strobe.
// RULE12 - Three power paths, each with its own gain and offset.
// RULE13 - Power offset is in result units; full scale gives 20,823,646.
// RULE14 - Software keeps current, voltage and power gain product within 3.75.
// RULE15 - Software calibrates rms offsets at small nonzero input.
// RULE16 - Power gain is one plus the signed value over 2^27.
// RULE17 - Compensated samples arrive once per processing sample period.
// RULE18 - Gains and offsets are signed; all results update on one strobe.
`timescale 1ns/1ps
`include "rapd_map.svh"
module rapd_datapath (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Processing sample stream
	input wire logic sample_stb_i,
	input wire rapd_pkg::rapd_wave_s wave_i,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Interrupt
	output logic irq_o
);
	import rapd_pkg::*;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	rapd_cfg_s cfg_q, cfg_d;
	logic [1:0] status_q, status_d;
	logic [1:0] mask_q, mask_d;
	logic [31:0] thresh_q, thresh_d;
	logic signed [31:0] rms_ofs_q [0:7];
	logic signed [31:0] rms_ofs_d [0:7];
	logic signed [31:0] pgain_q [0:2];
	logic signed [31:0] pgain_d [0:2];
	logic signed [31:0] pofs_q [0:2];
	logic signed [31:0] pofs_d [0:2];
	logic [31:0] rdata_q, rdata_d;
	logic wait_q, wait_d;
	logic irq_q, irq_d;
	logic [31:0] rd_mux;

	// ----------------------------------------
	// Datapath state
	// ----------------------------------------
	rapd_state_e state_q, state_d;
	logic [2:0] idx_q, idx_d;
	rapd_sample_t smp_q [0:7];
	rapd_sample_t smp_d [0:7];
	logic signed [63:0] lpf_q [0:10];
	logic signed [63:0] lpf_d [0:10];
	logic [31:0] rms_sh_q [0:7];
	logic [31:0] rms_sh_d [0:7];
	logic [31:0] pwr_sh_q [0:2];
	logic [31:0] pwr_sh_d [0:2];
	logic [31:0] rms_res_q [0:7];
	logic [31:0] rms_res_d [0:7];
	logic [31:0] pwr_res_q [0:2];
	logic [31:0] pwr_res_d [0:2];
	logic above_q, above_d;
	logic commit;
	logic mismatch_set;

	// Arithmetic terms
	rapd_sample_t mul_a, mul_b;
	logic signed [63:0] prod;
	logic [3:0] fidx;
	logic signed [63:0] lpf_new;
	logic signed [63:0] rad;
	logic signed [63:0] pwr_f;
	logic signed [63:0] pwr_s;
	logic signed [39:0] p40;
	logic signed [71:0] gp;
	logic signed [71:0] pw;
	logic signed [33:0] isum;
	logic sq_start;
	logic sq_done;
	logic [31:0] sq_root;

	rapd_sqrt u_sqrt (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.start_i(sq_start),
		.radicand_i(rad[63:0]),
		.done_o(sq_done),
		.root_o(sq_root)
	);

	// ----------------------------------------
	// Current sum selection
	// ----------------------------------------
	always_comb begin
		isum = 34'(wave_i.ia) + 34'(wave_i.ib) + 34'(wave_i.ic);
		unique case (cfg_q.isum_sel)
			2'h1: isum = isum + 34'(wave_i.ni); // [RULE8]
			2'h2: isum = isum - 34'(wave_i.ni); // [RULE8]
			default: isum = isum; // [RULE7]
		endcase
	end

	// ----------------------------------------
	// Sequencer and arithmetic
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		smp_d = smp_q;
		lpf_d = lpf_q;
		rms_sh_d = rms_sh_q;
		pwr_sh_d = pwr_sh_q;
		rms_res_d = rms_res_q;
		pwr_res_d = pwr_res_q;
		above_d = above_q;
		commit = 1'b0;
		mismatch_set = 1'b0;
		sq_start = 1'b0;
		// Shared multiplier: square in FILT, current times voltage in PWR
		mul_a = smp_q[idx_q];
		mul_b = smp_q[idx_q];
		fidx = {1'b0, idx_q};
		if (state_q == RAPD_PWR) begin
			mul_b = smp_q[3'd4 + idx_q]; // [RULE10]
			fidx = 4'd8 + {1'b0, idx_q};
		end
		prod = mul_a * mul_b; // [RULE1] [RULE10]
		lpf_new = lpf_q[fidx] + ((prod - lpf_q[fidx]) >>> `RAPD_LPF_SHIFT); // [RULE1]
		// Offset scaled by 2^15 and added to the squared rms [RULE4] [RULE5] [RULE6]
		rad = lpf_new + (64'(rms_ofs_q[idx_q]) <<< `RAPD_RMS_OFS_SHIFT);
		if (rad < 0) begin
			rad = '0;
		end
		pwr_f = cfg_q.bypass ? prod : lpf_new; // [RULE10]
		// Full-scale in-phase product over 2^27 lands on 20,823,646 [RULE13]
		pwr_s = pwr_f >>> `RAPD_PWR_SHIFT;
		p40 = pwr_s[39:0];
		gp = p40 * pgain_q[idx_q[1:0]]; // [RULE16] [RULE18]
		pw = 72'(p40) + (gp >>> `RAPD_GAIN_SHIFT) + 72'(pofs_q[idx_q[1:0]]); // [RULE12] [RULE13]
		unique case (state_q)
			RAPD_IDLE: begin
				if (sample_stb_i) begin // [RULE17]
					smp_d[0] = wave_i.ia;
					smp_d[1] = wave_i.ib;
					smp_d[2] = wave_i.ic;
					smp_d[3] = wave_i.ni; // [RULE5]
					smp_d[4] = wave_i.va;
					smp_d[5] = wave_i.vb;
					smp_d[6] = wave_i.vc;
					// Saturate so the square stays inside the filter range
					if (isum > 34'sh0_7fff_ffff) begin
						smp_d[7] = 32'sh7fff_ffff;
					end else if (isum < -34'sh0_8000_0000) begin
						smp_d[7] = 32'sh8000_0000;
					end else begin
						smp_d[7] = isum[31:0]; // [RULE6]
					end
					idx_d = 3'd0;
					state_d = RAPD_FILT;
				end
			end
			RAPD_FILT: begin
				lpf_d[fidx] = lpf_new; // [RULE1]
				sq_start = 1'b1;
				state_d = RAPD_ROOT;
			end
			RAPD_ROOT: begin
				if (sq_done) begin
					rms_sh_d[idx_q] = sq_root; // [RULE1] [RULE3]
					if (idx_q == 3'd7) begin
						idx_d = 3'd0;
						state_d = RAPD_PWR;
					end else begin
						idx_d = idx_q + 3'd1; // [RULE2]
						state_d = RAPD_FILT;
					end
				end
			end
			RAPD_PWR: begin
				lpf_d[fidx] = lpf_new;
				pwr_sh_d[idx_q[1:0]] = pw[31:0]; // [RULE12]
				if (idx_q == 3'd2) begin
					state_d = RAPD_COMMIT;
				end else begin
					idx_d = idx_q + 3'd1;
				end
			end
			RAPD_COMMIT: begin
				// All results change together on one edge [RULE18]
				rms_res_d = rms_sh_q; // [RULE2]
				pwr_res_d = pwr_sh_q; // [RULE11]
				commit = 1'b1;
				above_d = rms_sh_q[7] > thresh_q; // [RULE9]
				mismatch_set = (rms_sh_q[7] > thresh_q) != above_q; // [RULE9]
				state_d = RAPD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= RAPD_IDLE;
			idx_q <= 3'd0;
			above_q <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				smp_q[i] <= '0;
				rms_sh_q[i] <= '0;
				rms_res_q[i] <= '0;
			end
			for (int i = 0; i < 11; i++) begin
				lpf_q[i] <= '0;
			end
			for (int i = 0; i < 3; i++) begin
				pwr_sh_q[i] <= '0;
				pwr_res_q[i] <= '0;
			end
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
			above_q <= above_d;
			smp_q <= smp_d;
			lpf_q <= lpf_d;
			rms_sh_q <= rms_sh_d;
			pwr_sh_q <= pwr_sh_d;
			rms_res_q <= rms_res_d;
			pwr_res_q <= pwr_res_d;
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb begin
		rd_mux = '0;
		if (avs_address_i == `RAPD_OFS_CONFIG) begin
			rd_mux = {29'h0, cfg_q};
		end
		if (avs_address_i == `RAPD_OFS_STATUS) begin
			rd_mux = {30'h0, status_q};
		end
		if (avs_address_i == `RAPD_OFS_MASK) begin
			rd_mux = {30'h0, mask_q};
		end
		if (avs_address_i == `RAPD_OFS_THRESH) begin
			rd_mux = thresh_q;
		end
		for (int k = 0; k < 8; k++) begin
			if (avs_address_i == `RAPD_OFS_RMS_OFFSET + 8'(4 * k)) begin
				rd_mux = rms_ofs_q[k];
			end
			if (avs_address_i == `RAPD_OFS_RMS_RESULT + 8'(4 * k)) begin
				rd_mux = rms_res_q[k];
			end
		end
		for (int k = 0; k < 3; k++) begin
			if (avs_address_i == `RAPD_OFS_PWR_GAIN + 8'(4 * k)) begin
				rd_mux = pgain_q[k];
			end
			if (avs_address_i == `RAPD_OFS_PWR_OFFSET + 8'(4 * k)) begin
				rd_mux = pofs_q[k];
			end
			if (avs_address_i == `RAPD_OFS_PWR_RESULT + 8'(4 * k)) begin
				rd_mux = pwr_res_q[k];
			end
		end
	end

	// ----------------------------------------
	// Bus slave, status and interrupt
	// ----------------------------------------
	always_comb begin
		cfg_d = cfg_q;
		mask_d = mask_q;
		thresh_d = thresh_q;
		rms_ofs_d = rms_ofs_q;
		pgain_d = pgain_q;
		pofs_d = pofs_q;
		rdata_d = rdata_q;
		status_d = status_q;
		// One wait cycle per access: answer on the edge after the request is seen
		wait_d = !((avs_read_i || avs_write_i) && wait_q);
		if (avs_read_i && wait_q) begin
			rdata_d = rd_mux;
		end
		if (avs_write_i && !wait_q) begin
			if (avs_address_i == `RAPD_OFS_CONFIG) begin
				cfg_d.isum_sel = avs_writedata_i[`RAPD_CFG_ISUM_SEL_LSB +: 2];
				cfg_d.bypass = avs_writedata_i[`RAPD_CFG_BYPASS_BIT];
			end
			if (avs_address_i == `RAPD_OFS_STATUS) begin
				status_d = status_q & ~avs_writedata_i[1:0];
			end
			if (avs_address_i == `RAPD_OFS_MASK) begin
				mask_d = avs_writedata_i[1:0];
			end
			if (avs_address_i == `RAPD_OFS_THRESH) begin
				thresh_d = avs_writedata_i;
			end
			for (int k = 0; k < 8; k++) begin
				if (avs_address_i == `RAPD_OFS_RMS_OFFSET + 8'(4 * k)) begin
					rms_ofs_d[k] = avs_writedata_i;
				end
			end
			for (int k = 0; k < 3; k++) begin
				if (avs_address_i == `RAPD_OFS_PWR_GAIN + 8'(4 * k)) begin
					pgain_d[k] = avs_writedata_i;
				end
				if (avs_address_i == `RAPD_OFS_PWR_OFFSET + 8'(4 * k)) begin
					pofs_d[k] = avs_writedata_i;
				end
			end
		end
		// Hardware set wins over a same-cycle clear
		if (mismatch_set) begin
			status_d[`RAPD_ST_MISMATCH_BIT] = 1'b1; // [RULE9]
		end
		if (commit) begin
			status_d[`RAPD_ST_UPDATE_BIT] = 1'b1;
		end
		irq_d = |(status_d & mask_d); // [RULE9]
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_q <= '0;
			status_q <= `RAPD_RST_STATUS;
			mask_q <= `RAPD_RST_STATUS;
			thresh_q <= `RAPD_RST_WORD;
			rdata_q <= `RAPD_RST_WORD;
			wait_q <= 1'b1;
			irq_q <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				rms_ofs_q[i] <= '0;
			end
			for (int i = 0; i < 3; i++) begin
				pgain_q[i] <= '0;
				pofs_q[i] <= '0;
			end
		end else begin
			cfg_q <= cfg_d;
			status_q <= status_d;
			mask_q <= mask_d;
			thresh_q <= thresh_d;
			rdata_q <= rdata_d;
			wait_q <= wait_d;
			irq_q <= irq_d;
			rms_ofs_q <= rms_ofs_d;
			pgain_q <= pgain_d;
			pofs_q <= pofs_d;
		end
	end

	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign irq_o = irq_q;

endmodule : rapd_datapath

//--- rtl/rapd_sqrt.sv
// Iterative 64-bit integer square root, one result bit per clock
`timescale 1ns/1ps
`include "rapd_map.svh"
module rapd_sqrt (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Request
	input wire logic start_i,
	input wire logic [63:0] radicand_i,
	// Answer
	output logic done_o,
	output logic [31:0] root_o
);
	import rapd_pkg::*;

	logic [63:0] num_q, num_d;
	logic [63:0] res_q, res_d;
	logic [63:0] bit_q, bit_d;
	logic busy_q, busy_d;
	logic done_q, done_d;
	logic [63:0] trial;

	always_comb begin
		num_d = num_q;
		res_d = res_q;
		bit_d = bit_q;
		busy_d = busy_q;
		done_d = 1'b0;
		trial = res_q + bit_q;
		if (start_i && !busy_q) begin
			num_d = radicand_i;
			res_d = '0;
			bit_d = `RAPD_RST_SQRT_BIT;
			busy_d = 1'b1;
		end else if (busy_q) begin
			if (num_q >= trial) begin
				num_d = num_q - trial;
				res_d = (res_q >> 1) + bit_q;
			end else begin
				res_d = res_q >> 1;
			end
			bit_d = bit_q >> 2;
			if (bit_q == 64'h1) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			num_q <= '0;
			res_q <= '0;
			bit_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			num_q <= num_d;
			res_q <= res_d;
			bit_q <= bit_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign done_o = done_q;
	assign root_o = res_q[31:0];

endmodule : rapd_sqrt

//--- testbench/rapd_datapath_assertions.sv
// Bus, readback and interrupt checks for the rms and power datapath
`timescale 1ns/1ps
`include "rapd_map.svh"
module rapd_datapath_assertions (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Sample stream
	input wire logic sample_stb_i,
	input wire rapd_pkg::rapd_wave_s wave_i,
	// Register bus
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// Interrupt
	input wire logic irq_o
);
	import rapd_pkg::*;
	logic req;
	logic rd_ack;
	logic wr_ack;
	logic [2:0] cfg_q;
	logic [2:0] cfg_d;
	logic [1:0] mask_q;
	logic [1:0] mask_d;
	logic [31:0] thr_q;
	logic [31:0] thr_d;
	assign req = avs_read_i || avs_write_i;
	assign rd_ack = avs_read_i && !avs_waitrequest_o;
	assign wr_ack = avs_write_i && !avs_waitrequest_o;
	// ----------------------------------------
	// Shadow of writable settings
	// ----------------------------------------
	always_comb begin
		cfg_d = cfg_q;
		mask_d = mask_q;
		thr_d = thr_q;
		if (wr_ack && avs_address_i == `RAPD_OFS_CONFIG) cfg_d = avs_writedata_i[2:0];
		if (wr_ack && avs_address_i == `RAPD_OFS_MASK) mask_d = avs_writedata_i[1:0];
		if (wr_ack && avs_address_i == `RAPD_OFS_THRESH) thr_d = avs_writedata_i;
	end
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_q <= 3'h0;
			mask_q <= 2'h0;
			thr_q <= 32'h0;
		end else begin
			cfg_q <= cfg_d;
			mask_q <= mask_d;
			thr_q <= thr_d;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	ack_next_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("no ack");
	ack_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("ack too long");
	ack_cause_a: assert property (!avs_waitrequest_o |-> $past(req))
		else $error("ack without request");
	rd_hold_a:
	assert property (!(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
		else $error("read data moved");
	cfg_read_a:
	assert property (rd_ack && avs_address_i == `RAPD_OFS_CONFIG |-> avs_readdata_o == {29'h0, cfg_q})
		else $error("config readback wrong");
	thr_read_a:
	assert property (rd_ack && avs_address_i == `RAPD_OFS_THRESH |-> avs_readdata_o == thr_q)
		else $error("threshold readback wrong");
	irq_mask_a: assert property (irq_o |-> mask_q != 2'h0)
		else $error("irq while masked");
	unmapped_a: assert property (rd_ack && avs_address_i > 8'h70 |-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	cover property (rd_ack);
	cover property ($rose(irq_o));
	cover property (sample_stb_i);
	cover property (rd_ack && avs_address_i == `RAPD_OFS_STATUS && avs_readdata_o[0]);
endmodule : rapd_datapath_assertions

//--- testbench/rapd_datapath_tb.sv
// Self-checking bench for the rms and active power datapath
`timescale 1ns/1ps
`include "rapd_map.svh"
`define CHK(got, exp) begin \
	checks++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("ERROR %0t: got %h want %h", $time, got, exp); \
	end \
end
module rapd_datapath_tb;
	import rapd_pkg::*;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic sample_stb_i = 1'b0;
	rapd_wave_s wave_i = '0;
	logic [7:0] avs_address_i = 8'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic irq_o;
	int checks = 0;
	int fail_count = 0;
	int cycles = 0;
	rapd_datapath rapd_datapath_inst (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.sample_stb_i(sample_stb_i),
		.wave_i(wave_i),
		.avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.irq_o(irq_o)
	);
	initial begin
		forever #2.5 clock_i = ~clock_i;
	end
	task automatic summarize();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize
	// Hang guard, far above the few thousand cycles the run needs
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			$display("ERROR %0t: timeout", $time);
			summarize();
		end
	end
	// ----------------------------------------
	// Bus and stream helpers
	// ----------------------------------------
	task automatic rst();
		nrst_i <= 1'b0;
		repeat (5) @(posedge clock_i);
		nrst_i <= 1'b1;
		@(posedge clock_i);
	endtask : rst
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_read_i <= !w;
		avs_write_i <= w;
		// Wait as long as the slave asks; only the bench timeout ends a hang
		do begin
			@(posedge clock_i);
		end while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		// One idle edge so the next request never lands in the release step
		@(posedge clock_i);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHK(q, e)
	endtask : rc
	task automatic strobe(input rapd_wave_s w);
		logic [31:0] q;
		int n;
		n = 0;
		q = 32'h0;
		wr(`RAPD_OFS_STATUS, 32'h2);
		wave_i <= w;
		sample_stb_i <= 1'b1;
		@(posedge clock_i);
		sample_stb_i <= 1'b0;
		while (q[1] !== 1'b1 && n < 200) begin
			bus(1'b0, `RAPD_OFS_STATUS, 32'h0, q);
			n++;
		end
		`CHK(q[1], 1'b1)
	endtask : strobe
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		for (int a = 0; a < 8'h80; a += 4) begin
			rc(8'(a), 32'h0);
		end
		wr(8'h74, 32'hffff_ffff);
		wr(`RAPD_OFS_RMS_RESULT, 32'h1234_5678);
		rc(8'h74, 32'h0);
		rc(`RAPD_OFS_RMS_RESULT, 32'h0);
		wr(`RAPD_OFS_CONFIG, 32'hffff_ffff);
		rc(`RAPD_OFS_CONFIG, 32'h7);
	endtask : t_reset
	task automatic t_rms();
		logic [31:0] e[11] = '{32'h0010_0000, 32'h0010_0000, 32'h0008_001f,
			32'h0008_0000, 32'h0010_0000, 32'h0010_0000, 32'h0326_af15,
			32'h0030_0000, 32'h0000_2000, 32'hffff_e000, 32'h0003_26ac};
		rapd_wave_s w;
		// Voltage C is 32 times the full-scale rms code, so one strobe reads it back
		w = '{32'h0200_0000, 32'h0200_0000, 32'h0100_0000, 32'h0100_0000,
			32'h0200_0000, 32'hfe00_0000, 32'h64d5_e2a0};
		rst();
		wr(`RAPD_OFS_CONFIG, 32'h1);
		wr(`RAPD_OFS_THRESH, 32'd3000000);
		wr(`RAPD_OFS_MASK, 32'h1);
		wr(`RAPD_OFS_RMS_OFFSET + 8'd8, 32'h400);
		wr(`RAPD_OFS_PWR_OFFSET + 8'd8, 32'hffff_fffd);
		strobe(w);
		for (int i = 0; i < 11; i++) begin
			rc(`RAPD_OFS_RMS_RESULT + 8'(4 * i), e[i]);
		end
		rc(`RAPD_OFS_STATUS, 32'h3);
		`CHK(irq_o, 1'b1)
		wr(`RAPD_OFS_STATUS, 32'h1);
		rc(`RAPD_OFS_STATUS, 32'h2);
		`CHK(irq_o, 1'b0)
		wr(`RAPD_OFS_THRESH, 32'hffff_ffff);
		strobe(w);
		rc(`RAPD_OFS_STATUS, 32'h3);
		wr(`RAPD_OFS_STATUS, 32'h1);
		strobe(w);
		rc(`RAPD_OFS_STATUS, 32'h2);
	endtask : t_rms
	task automatic t_pwr();
		rapd_wave_s w;
		w = {7{32'h0200_0000}};
		w.ni = 32'h0;
		rst();
		wr(`RAPD_OFS_CONFIG, 32'h4);
		wr(`RAPD_OFS_PWR_GAIN + 8'd4, 32'h0400_0000);
		wr(`RAPD_OFS_PWR_GAIN + 8'd8, 32'hfc00_0000);
		wr(`RAPD_OFS_PWR_OFFSET, 32'h7);
		rc(`RAPD_OFS_PWR_GAIN + 8'd8, 32'hfc00_0000);
		strobe(w);
		rc(`RAPD_OFS_PWR_RESULT, 32'h0080_0007);
		rc(`RAPD_OFS_PWR_RESULT + 8'd4, 32'h00c0_0000);
		rc(`RAPD_OFS_PWR_RESULT + 8'd8, 32'h0040_0000);
		w.va = 32'hfe00_0000;
		w.vb = 32'hfe00_0000;
		w.vc = 32'hfe00_0000;
		strobe(w);
		rc(`RAPD_OFS_PWR_RESULT, 32'hff80_0007);
		rc(`RAPD_OFS_PWR_RESULT + 8'd4, 32'hff40_0000);
		rc(`RAPD_OFS_PWR_RESULT + 8'd8, 32'hffc0_0000);
	endtask : t_pwr
	task automatic t_sel();
		logic [31:0] e[4] = '{32'h0018_0000, 32'h0020_0000, 32'h0010_0000, 32'h0018_0000};
		for (int s = 0; s < 4; s++) begin
			rst();
			wr(`RAPD_OFS_CONFIG, 32'(s));
			strobe({{4{32'h0100_0000}}, 96'h0});
			rc(`RAPD_OFS_RMS_RESULT + 8'd28, e[s]);
		end
	endtask : t_sel
	initial begin
		rst();
		t_reset();
		t_rms();
		t_pwr();
		t_sel();
		summarize();
	end
endmodule : rapd_datapath_tb
bind rapd_datapath rapd_datapath_assertions rapd_datapath_assertions_inst (
	.clock_i(clock_i),
	.nrst_i(nrst_i),
	.sample_stb_i(sample_stb_i),
	.wave_i(wave_i),
	.avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i),
	.avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o),
	.irq_o(irq_o)
);
